//--- design/mid_pkg.sv
// package: constants, field layout and types of the instruction decoder
package mid_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int         OSC_PER_CYC = 4;
  localparam logic [1:0] PH_FIRST    = 2'h0;
  localparam logic [1:0] PH_LAST     = 2'(OSC_PER_CYC - 1);

  // ---------------------------------------------------------------
  // word layout
  // ---------------------------------------------------------------
  localparam int WORD_W    = 16;
  localparam int W_MSB     = WORD_W - 1;
  localparam int NIB_LSB   = 12;
  localparam int TOP5_LSB  = 11;
  localparam int TOP6_LSB  = 10;
  localparam int TOP7_LSB  = 9;
  localparam int HI_LSB    = 8;
  localparam int TOP14_LSB = 2;
  localparam int TOP15_LSB = 1;
  localparam int F_MSB     = 7;
  localparam int A_POS     = 8;
  localparam int D_POS     = 9;
  localparam int B_LSB     = 9;
  localparam int B_MSB     = 11;
  localparam int SUB_POS   = 11;
  localparam int OPX_LSB   = 10;
  localparam int OPX_MSB   = 11;
  localparam int K8_MSB    = 7;
  localparam int K4_MSB    = 3;
  localparam int FSR_LSB   = 4;
  localparam int FSR_MSB   = 5;
  localparam int N11_MSB   = 10;
  localparam int N8_MSB    = 7;
  localparam int S_RET_POS = 0;
  localparam int S_CAL_POS = 8;
  localparam int MM_MSB    = 1;
  localparam int OP2_MSB   = 11;

  // ---------------------------------------------------------------
  // opcode codes
  // ---------------------------------------------------------------
  localparam logic [3:0]  NIB_MISC  = 4'h0;
  localparam logic [3:0]  NIB_BYTE6 = 4'h6;
  localparam logic [3:0]  NIB_BTG   = 4'h7;
  localparam logic [3:0]  NIB_BSF   = 4'h8;
  localparam logic [3:0]  NIB_BCF   = 4'h9;
  localparam logic [3:0]  NIB_BTFSS = 4'ha;
  localparam logic [3:0]  NIB_BTFSC = 4'hb;
  localparam logic [3:0]  NIB_MOVFF = 4'hc;
  localparam logic [3:0]  NIB_BRA   = 4'hd;
  localparam logic [3:0]  NIB_E     = 4'he;
  localparam logic [3:0]  NIB_OP2   = 4'hf;
  localparam logic [3:0]  NIB_INFS  = 4'h4;
  localparam logic [1:0]  OPX_SKIP  = 2'h3;
  localparam logic [7:0]  HI_CTRL   = 8'h00;
  localparam logic [7:0]  HI_MOVLB  = 8'h01;
  localparam logic [7:0]  HI_RETLW  = 8'h0c;
  localparam logic [4:0]  T5_LIT    = 5'h01;
  localparam logic [6:0]  T7_MULWF  = 7'h01;
  localparam logic [5:0]  T6_DECF   = 6'h01;
  localparam logic [4:0]  T5_BCOND  = 5'h1c;
  localparam logic [5:0]  T6_EXT    = 6'h3a;
  localparam logic [7:0]  HI_MOVSX  = 8'heb;
  localparam logic [7:0]  HI_LFSR   = 8'hee;
  localparam logic [6:0]  T7_CALL   = 7'h76;
  localparam logic [7:0]  HI_GOTO   = 8'hef;
  localparam logic [1:0]  LFSR_PAD  = 2'h0;
  localparam logic [13:0] T14_TBLRD = 14'h0002;
  localparam logic [13:0] T14_TBLWT = 14'h0003;
  localparam logic [14:0] T15_RETFI = 15'h0008;
  localparam logic [14:0] T15_RETRN = 15'h0009;
  localparam logic [15:0] W_CALLW   = 16'h0014;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    CL_NOP  = 3'b000,
    CL_BYTE = 3'b001,
    CL_BIT  = 3'b010,
    CL_LIT  = 3'b011,
    CL_CTRL = 3'b100
  } mid_class_t;

  typedef enum logic [1:0] {
    TB_KEEP    = 2'b00,
    TB_POSTINC = 2'b01,
    TB_POSTDEC = 2'b10,
    TB_PREINC  = 2'b11
  } mid_tbl_t;

  typedef enum logic [0:0] {
    ST_EXEC = 1'b0,
    ST_OPND = 1'b1
  } mid_state_t;

  typedef struct packed {
    logic [1:0] phase;
    logic       cyc_en;
  } mid_phase_t;

  typedef struct packed {
    mid_state_t  st;
    logic        pend_jump;
    logic        pend_cond;
    logic        ins_valid;
    logic        op2_valid;
    logic        nop_cycle;
    mid_class_t  cls;
    logic [7:0]  opcode;
    logic        ext;
    logic        two_word;
    logic        pc_change;
    logic        cond;
    logic [7:0]  file_addr;
    logic        dest_file;
    logic        bsr_bank;
    logic [2:0]  bit_num;
    logic [7:0]  literal;
    logic [1:0]  fsr_sel;
    logic [10:0] prog_off;
    logic        fast;
    mid_tbl_t    tbl_mode;
    logic [11:0] op2_data;
  } mid_dec_t;

endpackage

//--- design/mid_phase.sv
// instruction cycle sequencer: four oscillator periods per cycle
`timescale 1ns/1ps
module mid_phase (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // cycle timing
  output logic [1:0]      phase,
  output logic            cyc_en
);
  import mid_pkg::*;

  mid_phase_t s_r;
  mid_phase_t s_nxt;

  always_comb begin
    s_nxt        = s_r;
    s_nxt.phase  = s_r.phase + 2'h1;
    s_nxt.cyc_en = (s_nxt.phase == PH_LAST);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign phase  = s_r.phase;
  assign cyc_en = s_r.cyc_en;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_cyc_period: assert property (@(posedge clk) disable iff (!rst_b)
    cyc_en |=> !cyc_en [*3] ##1 cyc_en)
    else $error("instruction cycle is not four clocks");

endmodule

//--- design/mid_decoder.sv
// instruction fetch and decode for an 8-bit microcontroller core
// ------------------------------------------------------------------
// Behaviour
// - one 16-bit word, five two-word instructions
// - split word into opcode and operand fields
// - classify byte, bit, literal, control
// - byte ops: register, destination, access bits
// - d=0 to working register, d=1 file
// - bit ops: register, bit number, access bit
// - literal ops: constant, pointer select, none
// - control: address, fast bit, table mode
// - lone second word executes as no-operation
// - taken condition or jump adds one NOP
// - two-word instructions take two cycles
// - instruction cycle is four oscillator periods
// - 75 core plus 8 extended instructions
// - a=0 access bank, a=1 bank select
// - fast bit selects shadow save/restore
// - four table pointer update modes
// ------------------------------------------------------------------
`timescale 1ns/1ps
module mid_decoder (
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst_b,
  // program memory
  input  wire logic [15:0]             prog_word,
  output logic                         fetch_adv,
  // execute feedback
  input  wire logic                    cond_true,
  // slot strobes
  output logic                         ins_valid,
  output logic                         op2_valid,
  output logic                         nop_cycle,
  // decoded instruction
  output mid_pkg::mid_class_t          ins_class,
  output logic [7:0]                   ins_opcode,
  output logic                         ins_ext,
  output logic                         ins_two_word,
  output logic                         ins_pc_change,
  output logic                         ins_cond,
  // operand fields
  output logic [7:0]                   file_addr,
  output logic                         dest_file,
  output logic                         dest_working_register,
  output logic                         bank_from_bsr,
  output logic                         access_bank,
  output logic [2:0]                   bit_num,
  output logic [7:0]                   literal,
  output logic [1:0]                   fsr_sel,
  output logic [10:0]                  prog_off,
  output logic                         fast_mode,
  output mid_pkg::mid_tbl_t            table_mode,
  output logic [11:0]                  op2_data
);
  import mid_pkg::*;

  // ---------------------------------------------------------------
  // cycle sequencer
  // ---------------------------------------------------------------
  logic       cyc_en;
  logic [1:0] phase;

  mid_phase u_phase (
    .clk    (clk),
    .rst_b  (rst_b),
    .phase  (phase),
    .cyc_en (cyc_en)
  );

  assign fetch_adv = cyc_en;

  // ---------------------------------------------------------------
  // combinational decode of the fetched word
  // ---------------------------------------------------------------
  logic [3:0]  nib;
  logic [7:0]  hi;
  mid_class_t  d_cls;
  logic        d_jump;
  logic        d_cond;
  logic        d_two;
  logic        d_ext;
  logic        d_fast;
  mid_tbl_t    d_tbl;
  logic [7:0]  d_lit;
  logic [10:0] d_off;

  assign nib = prog_word[W_MSB:NIB_LSB];
  assign hi  = prog_word[W_MSB:HI_LSB];

  always_comb begin
    d_cls  = CL_NOP;
    d_jump = 1'b0;
    d_cond = 1'b0;
    d_two  = 1'b0;
    d_ext  = 1'b0;
    d_fast = 1'b0;
    d_tbl  = TB_KEEP;
    d_lit  = prog_word[K8_MSB:0];
    d_off  = 11'(prog_word[N8_MSB:0]);
    unique case (nib)
      NIB_MISC: begin
        if (hi == HI_MOVLB || prog_word[W_MSB:TOP5_LSB] == T5_LIT) begin
          d_cls  = CL_LIT;
          d_jump = (hi == HI_RETLW);
        end else if (prog_word[W_MSB:TOP7_LSB] == T7_MULWF ||
                     prog_word[W_MSB:TOP6_LSB] == T6_DECF) begin
          d_cls = CL_BYTE;
        end else begin
          d_cls = CL_CTRL;
          if (prog_word[W_MSB:TOP15_LSB] == T15_RETRN ||
              prog_word[W_MSB:TOP15_LSB] == T15_RETFI) begin
            d_jump = 1'b1;
            d_fast = prog_word[S_RET_POS];
          end
          if (prog_word == W_CALLW) begin
            d_jump = 1'b1;
            d_ext  = 1'b1;
          end
          if (prog_word[W_MSB:TOP14_LSB] == T14_TBLRD ||
              prog_word[W_MSB:TOP14_LSB] == T14_TBLWT) begin
            d_tbl = mid_tbl_t'(prog_word[MM_MSB:0]);
          end
        end
      end
      4'h1, 4'h2, 4'h3, NIB_INFS, 4'h5, NIB_BYTE6: begin
        d_cls  = CL_BYTE;
        d_cond = (nib == NIB_BYTE6 && !prog_word[SUB_POS]) ||
                 (nib == NIB_INFS && prog_word[SUB_POS]) ||
                 ((nib == 4'h2 || nib == 4'h3) &&
                  prog_word[OPX_MSB:OPX_LSB] == OPX_SKIP);
      end
      NIB_BTG, NIB_BSF, NIB_BCF: begin
        d_cls = CL_BIT;
      end
      NIB_BTFSS, NIB_BTFSC: begin
        d_cls  = CL_BIT;
        d_cond = 1'b1;
      end
      NIB_MOVFF: begin
        d_cls = CL_BYTE;
        d_two = 1'b1;
      end
      NIB_BRA: begin
        d_cls  = CL_CTRL;
        d_jump = 1'b1;
        d_off  = prog_word[N11_MSB:0];
      end
      NIB_E: begin
        if (prog_word[W_MSB:TOP5_LSB] == T5_BCOND) begin
          d_cls  = CL_CTRL;
          d_cond = 1'b1;
        end else if (prog_word[W_MSB:TOP6_LSB] == T6_EXT) begin
          d_ext = 1'b1;
          d_cls = (hi == HI_MOVSX) ? CL_BYTE : CL_LIT;
          d_two = (hi == HI_MOVSX);
        end else if (hi == HI_LFSR &&
                     prog_word[K8_MSB:K8_MSB-1] == LFSR_PAD) begin
          d_cls = CL_LIT;
          d_two = 1'b1;
          d_lit = 8'(prog_word[K4_MSB:0]);
        end else if (prog_word[W_MSB:TOP7_LSB] == T7_CALL ||
                     hi == HI_GOTO) begin
          d_cls  = CL_CTRL;
          d_two  = 1'b1;
          d_fast = (hi != HI_GOTO) && prog_word[S_CAL_POS];
        end else begin
          d_cls = CL_NOP;
        end
      end
      NIB_OP2: begin
        d_cls = CL_NOP;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // slot sequencer and operand registers
  // ---------------------------------------------------------------
  mid_dec_t s_r;
  mid_dec_t s_nxt;
  logic     flush;

  assign flush = s_r.pend_jump || (s_r.pend_cond && cond_true);

  always_comb begin
    s_nxt           = s_r;
    s_nxt.ins_valid = 1'b0;
    s_nxt.op2_valid = 1'b0;
    s_nxt.nop_cycle = 1'b0;
    if (cyc_en) begin
      unique case (s_r.st)
        ST_OPND: begin
          s_nxt.op2_valid = 1'b1;
          s_nxt.op2_data  = prog_word[OP2_MSB:0];
          s_nxt.st        = ST_EXEC;
        end
        ST_EXEC: begin
          s_nxt.pend_jump = 1'b0;
          s_nxt.pend_cond = 1'b0;
          if (flush || nib == NIB_OP2) begin
            s_nxt.nop_cycle = 1'b1;
          end else begin
            s_nxt.ins_valid = 1'b1;
            s_nxt.cls       = d_cls;
            s_nxt.opcode    = hi;
            s_nxt.ext       = d_ext;
            s_nxt.two_word  = d_two;
            s_nxt.pc_change = d_jump;
            s_nxt.cond      = d_cond;
            s_nxt.file_addr = prog_word[F_MSB:0];
            s_nxt.dest_file = prog_word[D_POS];
            s_nxt.bsr_bank  = prog_word[A_POS];
            s_nxt.bit_num   = prog_word[B_MSB:B_LSB];
            s_nxt.literal   = d_lit;
            s_nxt.fsr_sel   = prog_word[FSR_MSB:FSR_LSB];
            s_nxt.prog_off  = d_off;
            s_nxt.fast      = d_fast;
            s_nxt.tbl_mode  = d_tbl;
            s_nxt.pend_jump = d_jump;
            s_nxt.pend_cond = d_cond;
            s_nxt.st        = d_two ? ST_OPND : ST_EXEC;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign ins_valid     = s_r.ins_valid;
  assign op2_valid     = s_r.op2_valid;
  assign nop_cycle     = s_r.nop_cycle;
  assign ins_class     = s_r.cls;
  assign ins_opcode    = s_r.opcode;
  assign ins_ext       = s_r.ext;
  assign ins_two_word  = s_r.two_word;
  assign ins_pc_change = s_r.pc_change;
  assign ins_cond      = s_r.cond;
  assign file_addr     = s_r.file_addr;
  assign dest_file     = s_r.dest_file;
  assign dest_working_register     = !s_r.dest_file;
  assign bank_from_bsr = s_r.bsr_bank;
  assign access_bank   = !s_r.bsr_bank;
  assign bit_num       = s_r.bit_num;
  assign literal       = s_r.literal;
  assign fsr_sel       = s_r.fsr_sel;
  assign prog_off      = s_r.prog_off;
  assign fast_mode     = s_r.fast;
  assign table_mode    = s_r.tbl_mode;
  assign op2_data      = s_r.op2_data;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_slot_onehot: assert property (
    $onehot0({ins_valid, op2_valid, nop_cycle}))
    else $error("more than one slot strobe at once");
  a_jump_flush: assert property (
    ins_valid && ins_pc_change |-> ##4 nop_cycle)
    else $error("jump not followed by a nop cycle");
  a_cond_flush: assert property (
    ins_valid && ins_cond ##3 cond_true |=> nop_cycle)
    else $error("taken condition not followed by a nop cycle");
  a_single_cycle: assert property (
    ins_valid && !ins_pc_change && !ins_cond && !ins_two_word
    ##3 prog_word[W_MSB:NIB_LSB] != NIB_OP2 |=> !nop_cycle)
    else $error("plain instruction took an extra cycle");
  a_two_word_op: assert property (
    ins_valid && ins_two_word |-> ##4 (op2_valid && !ins_valid))
    else $error("second word not captured as operand");
  a_lone_second: assert property (
    cyc_en && s_r.st == ST_EXEC && !flush && nib == NIB_OP2
    |=> nop_cycle && !ins_valid)
    else $error("lone second word not run as nop");
  a_dest_select: assert property (
    ins_valid && ins_class == CL_BYTE
    |-> dest_working_register == !$past(prog_word[D_POS]))
    else $error("destination select wrong");
  a_bank_select: assert property (
    ins_valid && (ins_class == CL_BYTE || ins_class == CL_BIT)
    |-> access_bank == !$past(prog_word[A_POS]))
    else $error("bank select wrong");
  a_bit_number: assert property (
    ins_valid && ins_class == CL_BIT
    |-> bit_num == $past(prog_word[B_MSB:B_LSB]))
    else $error("bit number wrong");
  a_table_mode: assert property (
    ins_valid && $past(prog_word[W_MSB:TOP14_LSB]) == T14_TBLRD
    |-> table_mode == mid_tbl_t'($past(prog_word[MM_MSB:0])))
    else $error("table pointer mode wrong");
  a_fast_return: assert property (
    ins_valid && $past(prog_word[W_MSB:TOP15_LSB]) == T15_RETRN
    |-> fast_mode == $past(prog_word[S_RET_POS]))
    else $error("fast mode bit wrong on return");

  c_two_word: cover property (ins_valid && ins_two_word ##4 op2_valid);
  c_jump: cover property (ins_valid && ins_pc_change ##4 nop_cycle);
  c_skip: cover property (ins_valid && ins_cond ##4 nop_cycle);
  c_ext: cover property (ins_valid && ins_ext);

endmodule

//--- tb/mid_pmem.sv
// program memory stand-in: one word and one condition flag per address
`timescale 1ns/1ps
module mid_pmem (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // fetch side
  input  wire logic        fetch_adv,
  output logic [15:0]      prog_word,
  // datapath condition stand-in
  output logic             cond_true
);
  logic [15:0] mem [0:63];
  logic        cflg [0:63];
  logic [5:0]  addr_r;

  // -----------------------------------------------------------------
  // one word per take, address moves just after the take edge
  // -----------------------------------------------------------------
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) addr_r <= 6'h0;
    else if (fetch_adv) addr_r <= #1 addr_r + 6'h1;
  end

  assign prog_word = mem[addr_r];
  assign cond_true = cflg[addr_r];
endmodule

//--- tb/testbench.sv
// testbench: program sequences checked against decode expectations
`timescale 1ns/1ps
module testbench;
  import mid_pkg::*;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [15:0] prog_word;
  logic        fetch_adv, cond_true, ins_valid, op2_valid, nop_cycle;
  mid_class_t  ins_class;
  mid_tbl_t    table_mode;
  logic [7:0]  ins_opcode, file_addr, literal;
  logic        ins_ext, ins_two_word, ins_pc_change, ins_cond;
  logic        dest_file, dest_working_register, bank_from_bsr, access_bank, fast_mode;
  logic [2:0]  bit_num;
  logic [1:0]  fsr_sel;
  logic [10:0] prog_off;
  logic [11:0] op2_data;
  int          n_mismatch = 0, comparisons = 0, seed = 66195;
  int          cyc = 0, t_prev = 0;
  logic        exp_op2 = 1'b0, pend_j = 1'b0, pend_c = 1'b0;
  localparam logic [15:0] hand_w [0:42] = '{
    16'hd005, 16'h1234, 16'hb3a0, 16'h5e21, 16'ha5c1, 16'h1111, 16'hef12,
    16'hf345, 16'h1ab0, 16'hc123, 16'hf456, 16'hee12, 16'hf034, 16'hf777,
    16'hd7ff, 16'hed01, 16'hf002, 16'h0013, 16'h0000, 16'hec55, 16'hf100,
    16'h0008, 16'h0009, 16'h000a, 16'h000b, 16'h000e, 16'h0014, 16'h0000,
    16'he3f0, 16'h1010, 16'h0107, 16'h0c33, 16'h1010, 16'he812, 16'heb05,
    16'hf0aa, 16'hed34, 16'hf0bb, 16'h0312, 16'hee80, 16'h1234, 16'hf111,
    16'h2c05};

  mid_decoder dut_u (.clk, .rst_b, .prog_word, .fetch_adv, .cond_true,
    .ins_valid, .op2_valid, .nop_cycle, .ins_class, .ins_opcode, .ins_ext,
    .ins_two_word, .ins_pc_change, .ins_cond, .file_addr, .dest_file,
    .dest_working_register, .bank_from_bsr, .access_bank, .bit_num, .literal, .fsr_sel,
    .prog_off, .fast_mode, .table_mode, .op2_data);
  mid_pmem pmem_u (.clk, .rst_b, .fetch_adv, .prog_word, .cond_true);

  always #12.5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  // -----------------------------------------------------------------
  // expectations
  // -----------------------------------------------------------------
  function automatic logic [2:0] e_cls(input logic [15:0] w);
    case (w[15:12])
      4'h0:    return (w[11:8] == 4'h0) ? 3'h4 :
                      (w[11:8] == 4'h1 || w[11]) ? 3'h3 : 3'h1;
      4'h7, 4'h8, 4'h9, 4'ha, 4'hb: return 3'h2;
      4'hd:                         return 3'h4;
      4'he:    return !w[11] ? 3'h4 : (w[11:10] == 2'h2) ?
                      ((w[9:8] == 2'h3) ? 3'h1 : 3'h3) :
                      (w[11:8] != 4'he) ? 3'h4 :
                      (w[7:6] == 2'h0) ? 3'h3 : 3'h0;
      4'hf:    return 3'h0;
      default: return 3'h1;
    endcase
  endfunction
  function automatic logic e_two(input logic [15:0] w);
    return w[15:12] == 4'hc || w[15:8] == 8'heb || w[15:8] == 8'hef ||
           w[15:9] == 7'h76 || w[15:6] == 10'h3b8;
  endfunction
  function automatic logic e_pc(input logic [15:0] w);
    return w[15:12] == 4'hd || w[15:2] == 14'h0004 || w == 16'h0014 ||
           w[15:8] == 8'h0c;
  endfunction
  function automatic logic e_cnd(input logic [15:0] w);
    return w[15:13] == 3'h5 || w[15:11] == 5'h1c ||
           (w[15:12] == 4'h6 && !w[11]) || (w[15:12] == 4'h4 && w[11]) ||
           (w[15:13] == 3'h1 && w[11:10] == 2'h3);
  endfunction

  // -----------------------------------------------------------------
  // compare and report
  // -----------------------------------------------------------------
  task automatic close_out;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk1(input logic g, input logic e, input string m);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %0t %s got %b exp %b", $time, m, g, e);
    end
  endtask
  task automatic chkv(input logic [15:0] g, input logic [15:0] e,
                      input string m);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic wait_take;
    for (int i = 0; i < 8 && fetch_adv !== 1'b1; i++) begin
      @(posedge clk);
      #2;
    end
    if (fetch_adv !== 1'b1) begin
      n_mismatch++;
      $display("[ERR] %0t no fetch pulse", $time);
      close_out;
    end
  endtask

  // one cycle after a take: strobe kind and decoded fields
  task automatic check_take(input logic [15:0] w, input logic c);
    logic   ins;
    logic [2:0] k;
    ins = !(exp_op2 || pend_j || (pend_c && c) || w[15:12] == 4'hf);
    k = e_cls(w);
    chk1(fetch_adv, 1'b0, "fetch pulse");
    chk1(op2_valid, exp_op2, "op2 strobe");
    chk1(ins_valid, ins, "ins strobe");
    chk1(nop_cycle, !exp_op2 && !ins, "nop strobe");
    if (exp_op2) chkv(16'(op2_data), 16'(w[11:0]), "op2 data");
    if (ins) begin
      chkv(16'(ins_class), 16'(k), "class");
      chkv(16'(ins_opcode), 16'(w[15:8]), "opcode");
      chk1(ins_two_word, e_two(w), "two word");
      chk1(ins_pc_change, e_pc(w), "pc change");
      chk1(ins_cond, e_cnd(w), "cond");
      chk1(ins_ext, w[15:10] == 6'h3a || w == 16'h0014, "ext");
      if ((k == 3'h1 || k == 3'h2) && w[15:12] != 4'hc) begin
        chkv(16'(file_addr), 16'(w[7:0]), "file");
        chk1(bank_from_bsr, w[8], "bank");
        chk1(access_bank, !w[8], "access");
      end
      if (k == 3'h1 && w[15:12] != 4'hc) begin
        chk1(dest_file, w[9], "dest");
        chk1(dest_working_register, !w[9], "working_register");
      end
      if (k == 3'h2) chkv(16'(bit_num), 16'(w[11:9]), "bit");
      if (k == 3'h3) chkv(16'(literal), (w[15:8] == 8'hee) ?
        16'(w[3:0]) : 16'(w[7:0]), "literal");
      if (w[15:8] == 8'hee) chkv(16'(fsr_sel), 16'(w[5:4]), "fsr");
      if (w[15:12] == 4'hd) chkv(16'(prog_off), 16'(w[10:0]), "off");
      if (w[15:11] == 5'h1c) chkv(16'(prog_off), 16'(w[7:0]), "off8");
      if (w[15:3] == 13'h0001)
        chkv(16'(table_mode), 16'(w[1:0]), "table");
      if (w[15:1] == 15'h0009) chk1(fast_mode, w[0], "fast ret");
      if (w[15:9] == 7'h76) chk1(fast_mode, w[8], "fast call");
    end
    if (exp_op2) exp_op2 = 1'b0;
    else begin
      pend_j = ins && e_pc(w);
      pend_c = ins && e_cnd(w);
      exp_op2 = ins && e_two(w);
    end
  endtask

  // -----------------------------------------------------------------
  // main sequence
  // -----------------------------------------------------------------
  initial begin
    logic [31:0] r;
    logic [15:0] w;
    for (int k = 0; k < 64; k++) begin
      r = $random(seed);
      case (r[17:16])
        2'h1:    w = {4'h7 + 4'(r[14:12] % 5), r[11:0]};
        2'h2:    w = {4'h0, (r[14:12] == 3'h4) ? 4'hf :
                      4'h8 + 4'(r[14:12]), r[7:0]};
        default: w = {4'h1 + 4'(r[14:12] % 6), r[11:0]};
      endcase
      if (k < 43) w = hand_w[k];
      pmem_u.mem[k] = w;
      pmem_u.cflg[k] = (k == 5) ? 1'b1 : (k == 3) ? 1'b0 : r[20];
    end
    repeat (10) @(posedge clk);
    #2;
    chk1(fetch_adv, 1'b0, "reset fetch");
    chk1(dest_working_register, 1'b1, "reset working_register");
    rst_b = 1'b1;
    for (int k = 0; k < 3; k++) begin
      @(posedge clk);
      #2;
      chk1(fetch_adv, k == 2, "first fetch");
    end
    for (int k = 0; k < 64; k++) begin
      wait_take;
      if (k > 0) chkv(16'(cyc - t_prev), 16'h4, "cycle spacing");
      t_prev = cyc;
      @(posedge clk);
      #2;
      check_take(pmem_u.mem[k], pmem_u.cflg[k]);
    end
    rst_b = 1'b0;
    #1;
    chk1(fetch_adv, 1'b0, "mid reset fetch");
    chk1(ins_valid, 1'b0, "mid reset strobe");
    chk1(access_bank, 1'b1, "mid reset access");
    repeat (2) @(posedge clk);
    #2 rst_b = 1'b1;
    for (int k = 0; k < 3; k++) begin
      @(posedge clk);
      #2;
      chk1(fetch_adv, k == 2, "refetch");
    end
    close_out;
  end
endmodule
